/* File: hdl/cca_core.v */
// cca_core.v: fetch/decode/execute for absolute call/jump, add, add_with_carry_op and logical and
// assumes single-cycle synchronous program memory and data space reads (data next cycle)
`timescale 1ns/10ps
`default_nettype none
`include "cca_defs.vh"
module cca_core (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire [7:0]  i_code,      // program byte at o_code_addr, valid next cycle
	input  wire [7:0]  i_rdata,     // data byte at o_addr, valid next cycle; latch for ports
	output reg  [15:0] o_code_addr,
	output reg  [7:0]  o_addr,
	output reg         o_sfr,       // address targets special register space
	output reg         o_rd,
	output reg         o_wr,
	output reg  [7:0]  o_wdata,
	output reg  [7:0]  o_acc,
	output reg  [7:0]  o_psw,
	output reg  [7:0]  o_sp,
	output reg  [15:0] o_pc,
	output reg         o_illegal
);
	localparam S_FETCH = 6'h01;
	localparam S_OPER  = 6'h02;
	localparam S_READ  = 6'h04;
	localparam S_EXEC  = 6'h08;
	localparam S_PUSHH = 6'h10;
	localparam S_IMM2  = 6'h20;

	reg [5:0] st_q;
	reg [7:0] op_q;
	reg [7:0] b2_q;
	reg [7:0] rsrc_q;
	reg [2:0] idx_q;
	wire [4:0] bank_base;
	wire [7:0] alu_res;
	wire alu_cy;
	wire alu_ac;
	wire alu_ov;
	wire is_add;
	wire is_add_with_carry_op;
	wire is_anl;
	wire src_bit;
	wire [15:0] pc2;

	assign bank_base = {o_psw[`CCA_PSW_RS1], o_psw[`CCA_PSW_RS0], 3'h0};
	assign is_add  = op_q[7:4] == `CCA_OP_ADD_HI;
	assign is_add_with_carry_op = op_q[7:4] == `CCA_OP_ADD_WITH_CARRY_OP_HI;
	assign is_anl  = op_q[7:4] == `CCA_OP_ANL_HI;
	// relative branches are outside this subset, so no offset adder
	assign pc2 = o_pc + 16'h0001; // full 16-bit counter
	// bit operand read selects the byte; bit index from low three address bits
	assign src_bit = i_rdata[idx_q] ^ (op_q == `CCA_OP_ANLC_NBIT);

	cca_alu u_alu (
		.i_a   (o_acc),
		.i_b   (rsrc_q),
		.i_cin (is_add_with_carry_op & o_psw[`CCA_PSW_CY]),
		.i_and (is_anl),
		.o_res (alu_res),
		.o_cy  (alu_cy),
		.o_ac  (alu_ac),
		.o_ov  (alu_ov)
	);

	// direct space decode
	task set_direct;
		input [7:0] a;
		begin
			o_addr <= a;
			o_sfr  <= a >= `CCA_SFR_BASE;
			o_rd   <= 1'b1;
		end
	endtask

	// sequencer; reads complete one cycle after o_rd
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= S_FETCH;
			op_q <= 8'h00;
			b2_q <= 8'h00;
			rsrc_q <= 8'h00;
			idx_q <= 3'h0;
			o_code_addr <= `CCA_PC_RST;
			o_addr <= 8'h00;
			o_sfr <= 1'b0;
			o_rd <= 1'b0;
			o_wr <= 1'b0;
			o_wdata <= 8'h00;
			o_acc <= 8'h00;
			o_psw <= 8'h00;
			o_sp <= `CCA_SP_RST;
			o_pc <= `CCA_PC_RST;
			o_illegal <= 1'b0;
		end else begin
			o_rd <= 1'b0;
			o_wr <= 1'b0;
			o_illegal <= 1'b0;
			case (st_q)
				S_FETCH: begin
					op_q <= i_code;
					o_pc <= pc2;
					o_code_addr <= pc2;
					st_q <= S_OPER;
					// register and indirect forms fetch operand now
					if (i_code[7:4] == `CCA_OP_ADD_HI || i_code[7:4] == `CCA_OP_ADD_WITH_CARRY_OP_HI ||
						i_code[7:4] == `CCA_OP_ANL_HI) begin
						if (i_code[3]) begin
							o_addr <= {3'h0, bank_base} | {5'h00, i_code[2:0]};
							o_sfr <= 1'b0;
							o_rd <= 1'b1;
							st_q <= S_READ;
						end else if (i_code[3:1] == 3'h3) begin
							o_addr <= {3'h0, bank_base} | {7'h00, i_code[0]};
							o_sfr <= 1'b0;
							o_rd <= 1'b1;
							st_q <= S_PUSHH;
						end
					end
				end
				S_OPER: begin
					b2_q <= i_code;
					if (op_q[4:0] == `CCA_OP_ABSOLUTE_CALL_OP_LO) begin
						o_pc <= pc2;
						o_sp <= o_sp + 8'h01;
						o_addr <= o_sp + 8'h01;
						o_sfr <= 1'b0;
						o_wdata <= pc2[7:0];
						o_wr <= 1'b1;
						st_q <= S_EXEC;
					end else if (op_q[4:0] == `CCA_OP_ABSOLUTE_JUMP_OP_LO) begin
						o_pc <= {pc2[15:11], op_q[7:5], i_code};
						o_code_addr <= {pc2[15:11], op_q[7:5], i_code};
						st_q <= S_IMM2; // third cycle, no stack
					end else if (op_q[3:0] == 4'h4 && (is_add || is_add_with_carry_op || is_anl)) begin
						o_pc <= pc2;
						o_code_addr <= pc2;
						rsrc_q <= i_code;
						st_q <= S_EXEC; // immediate
						o_addr <= 8'h00;
					end else if (op_q[3:0] == 4'h5 && (is_add || is_add_with_carry_op || is_anl)) begin
						o_pc <= pc2;
						o_code_addr <= pc2;
						set_direct(i_code);
						st_q <= S_READ;
					end else if (op_q == `CCA_OP_ANL_DA || op_q == `CCA_OP_ANL_DI) begin
						o_pc <= pc2;
						o_code_addr <= pc2;
						set_direct(i_code); // latch read for ports
						st_q <= S_READ;
					end else if (op_q == `CCA_OP_ANLC_BIT || op_q == `CCA_OP_ANLC_NBIT) begin
						o_pc <= pc2;
						o_code_addr <= pc2;
						idx_q <= i_code[2:0];
						// bit space: low half maps 0x20..0x2f, high half byte-aligned sfr
						set_direct(i_code[7] ? {i_code[7:3], 3'h0} :
							{4'h2, i_code[6:3]});
						st_q <= S_READ;
					end else begin
						o_illegal <= 1'b1; // unsupported opcode skipped as one byte
						st_q <= S_FETCH;
					end
				end
				S_PUSHH: begin
					// indirect: pointer value now addresses full ram
					o_addr <= i_rdata;
					o_sfr <= 1'b0;
					o_rd <= 1'b1;
					st_q <= S_READ;
				end
				S_READ: begin
					rsrc_q <= i_rdata;
					if (op_q == `CCA_OP_ANLC_BIT || op_q == `CCA_OP_ANLC_NBIT) begin
						if (!src_bit)
							o_psw[`CCA_PSW_CY] <= 1'b0;
						st_q <= S_FETCH;
					end else if (op_q == `CCA_OP_ANL_DA) begin
						o_wdata <= i_rdata & o_acc;
						o_wr <= 1'b1;
						st_q <= S_FETCH;
					end else if (op_q == `CCA_OP_ANL_DI) begin
						st_q <= S_IMM2; // third byte holds mask
					end else begin
						st_q <= S_EXEC;
					end
				end
				S_EXEC: begin
					if (op_q[4:0] == `CCA_OP_ABSOLUTE_CALL_OP_LO) begin
						o_sp <= o_sp + 8'h01;
						o_addr <= o_sp + 8'h01;
						o_wdata <= o_pc[15:8];
						o_wr <= 1'b1;
						o_pc <= {o_pc[15:11], op_q[7:5], b2_q};
						o_code_addr <= {o_pc[15:11], op_q[7:5], b2_q};
					end else begin
						o_acc <= alu_res;
						if (!is_anl) begin
							o_psw[`CCA_PSW_CY] <= alu_cy;
							o_psw[`CCA_PSW_AC] <= alu_ac;
							o_psw[`CCA_PSW_OV] <= alu_ov;
						end
					end
					st_q <= S_FETCH;
				end
				S_IMM2: begin
					if (op_q == `CCA_OP_ANL_DI) begin
						o_wdata <= rsrc_q & i_code;
						o_wr <= 1'b1;
						o_pc <= pc2;
						o_code_addr <= pc2;
					end
					st_q <= S_FETCH;
				end
				default: st_q <= S_FETCH;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: inc/cca_defs.vh */
// cca_defs.vh: opcodes, address ranges, reset values and psw bits for the call/add/and executor
// assumes inclusion by bare name from design files
`ifndef CCA_DEFS_VH
`define CCA_DEFS_VH
`define CCA_SFR_BASE      8'h80
`define CCA_SP_RST        8'h07
`define CCA_PC_RST        16'h0000
`define CCA_OP_ABSOLUTE_CALL_OP_LO   5'h11
`define CCA_OP_ABSOLUTE_JUMP_OP_LO    5'h01
`define CCA_OP_ADD_HI     4'h2
`define CCA_OP_ADD_WITH_CARRY_OP_HI    4'h3
`define CCA_OP_ANL_HI     4'h5
`define CCA_OP_ANL_DA     8'h52
`define CCA_OP_ANL_DI     8'h53
`define CCA_OP_ANLC_BIT   8'h82
`define CCA_OP_ANLC_NBIT  8'hb0
`define CCA_PSW_CY        7
`define CCA_PSW_AC        6
`define CCA_PSW_RS1       4
`define CCA_PSW_RS0       3
`define CCA_PSW_OV        2
`endif

/* File: hdl/cca_alu.v */
// cca_alu.v: combinational add and and unit with flag generation
// assumes operands are stable for the cycle in which the result is used
`timescale 1ns/10ps
`default_nettype none
module cca_alu (
	input  wire [7:0] i_a,
	input  wire [7:0] i_b,
	input  wire       i_cin,
	input  wire       i_and,
	output wire [7:0] o_res,
	output wire       o_cy,
	output wire       o_ac,
	output wire       o_ov
);
	wire [4:0] lo;
	wire [3:0] mid;
	wire [1:0] hi;
	// split add exposes carries out of bits 3, 6 and 7
	assign lo  = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
	assign mid = {1'b0, i_a[6:4]} + {1'b0, i_b[6:4]} + {3'h0, lo[4]};
	assign hi  = {1'b0, i_a[7]} + {1'b0, i_b[7]} + {1'b0, mid[3]};
	assign o_res = i_and ? (i_a & i_b) : {hi[0], mid[2:0], lo[3:0]};
	assign o_cy  = hi[1];
	assign o_ac  = lo[4];
	assign o_ov  = hi[1] ^ mid[3];
endmodule
`default_nettype wire

/* File: test/cca_core_asserts.sv */
// port checker for cca_core
// assumes binding onto every cca_core instance
`timescale 1ns/10ps
`default_nettype none
module cca_core_asserts (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic [7:0]  o_addr,
	input wire logic        o_sfr,
	input wire logic        o_rd,
	input wire logic        o_wr,
	input wire logic [7:0]  o_wdata,
	input wire logic [7:0]  o_psw,
	input wire logic [7:0]  o_sp,
	input wire logic [15:0] o_pc
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// push pair: second byte one above the first
	property p_push_pair; o_wr ##1 o_wr |-> o_addr == $past(o_addr) + 8'h01; endproperty
	a_push_pair: assert property (p_push_pair) else $error("push pair not adjacent");
	property p_sp_step; $changed(o_sp) |-> o_sp - $past(o_sp) inside {8'h01, 8'h02}; endproperty
	a_sp_step: assert property (p_sp_step) else $error("stack pointer jumped");
	// stack moves only around a push, so a plain jump leaves it alone
	property p_sp_wr; $changed(o_sp) |-> $past(o_wr) or (##[0:1] o_wr); endproperty
	a_sp_wr: assert property (p_sp_wr) else $error("stack moved without push");
	property p_push_hi; o_wr ##1 o_wr |-> ##[1:3] o_pc[15:11] == o_wdata[7:3]; endproperty
	a_push_hi: assert property (p_push_hi) else $error("call left its page");
	property p_page; $changed(o_pc[15:11]) |-> o_pc - $past(o_pc) inside {16'h1, 16'h2}; endproperty
	a_page: assert property (p_page) else $error("page bits reloaded");
	property p_sfr_map; (o_rd || o_wr) && o_sfr |-> o_addr[7]; endproperty
	a_sfr_map: assert property (p_sfr_map) else $error("low address sent to sfr");
	property p_bank; $stable(o_psw[4:3]); endproperty
	a_bank: assert property (p_bank) else $error("bank select moved");
	// port write must follow a latch read
	property p_rmw; o_wr && o_sfr |-> $past(o_rd) || $past(o_rd, 2) || $past(o_rd, 3); endproperty
	a_rmw: assert property (p_rmw) else $error("port write without read");
	c_push: cover property (o_wr ##1 o_wr);
	c_port: cover property (o_wr && o_sfr);
	c_ind: cover property (o_rd && !o_sfr && o_addr[7]);
endmodule
bind cca_core cca_core_asserts chk (.i_clk, .i_rst, .o_addr, .o_sfr, .o_rd, .o_wr, .o_wdata,
	.o_psw, .o_sp, .o_pc);
`default_nettype wire

/* File: test/cca_mem.sv */
// program memory, internal ram and special registers beside cca_core
// assumes the bench preloads the arrays by hierarchy
`timescale 1ns/10ps
`default_nettype none
module cca_mem (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_code_addr,
	input  wire logic [7:0]  i_addr,
	input  wire logic        i_sfr,
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic [7:0]  i_wdata,
	output var  logic [7:0]  o_code,
	output var  logic [7:0]  o_rdata
);
	logic [7:0] rom [0:4095];
	logic [7:0] ram [0:255];
	logic [7:0] special_function_register [0:255];
	initial o_code = 8'h00;
	initial o_rdata = 8'h00;
	// answer half a cycle on; idle data flips so a stale byte never passes
	always @(negedge i_clk) begin
		o_code <= rom[i_code_addr[11:0]];
		o_rdata <= i_rd ? (i_sfr ? special_function_register[i_addr] : ram[i_addr]) : ~o_rdata;
	end
	// sfr array is the port latch, so reads return it, not pins
	always @(posedge i_clk) begin
		if (i_wr && i_sfr) special_function_register[i_addr] <= i_wdata;
		else if (i_wr) ram[i_addr] <= i_wdata;
	end
endmodule
`default_nettype wire

/* File: test/cca_core_tb.sv */
// self-checking bench for cca_core: short programs run from reset
// assumes cca_mem answers fetches and reads half a cycle later
`timescale 1ns/10ps
`default_nettype none
module cca_core_tb;
	logic        i_clk, i_rst, o_sfr, o_rd, o_wr, o_illegal;
	logic [7:0]  i_code, i_rdata, o_addr, o_wdata, o_acc, o_psw, o_sp;
	logic [15:0] o_code_addr, o_pc;
	int          error_cnt, cmp_count, cyc;
	logic [15:0] ill_cnt;
	cca_core uut (.i_clk, .i_rst, .i_code, .i_rdata, .o_code_addr, .o_addr, .o_sfr, .o_rd,
		.o_wr, .o_wdata, .o_acc, .o_psw, .o_sp, .o_pc, .o_illegal);
	cca_mem mem (.i_clk(i_clk), .i_code_addr(o_code_addr), .i_addr(o_addr), .i_sfr(o_sfr),
		.i_rd(o_rd), .i_wr(o_wr), .i_wdata(o_wdata), .o_code(i_code), .o_rdata(i_rdata));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	// hang guard, well above six short programs
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			finish_test();
		end
	end
	// unsupported opcode pulses, counted at the falling edge where they have settled
	always @(negedge i_clk) begin
		if (o_illegal === 1'b1) ill_cnt++;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// reset, load program plus a self-jump, run until the pc parks there
	task automatic run(input logic [7:0] prog[$], input logic [15:0] stop);
		int n;
		i_rst = 1'b1;
		ill_cnt = 16'h0000;
		foreach (prog[k]) mem.rom[k] = prog[k];
		mem.rom[stop[11:0]] = {stop[10:8], 5'h01};
		mem.rom[stop[11:0] + 12'h1] = stop[7:0];
		mem.ram[8'h00] = 8'haa;
		mem.ram[8'h20] = 8'h01;
		mem.ram[8'h21] = 8'hf0;
		mem.ram[8'haa] = 8'h0f;
		mem.special_function_register[8'h90] = 8'hff;
		repeat (8) @(negedge i_clk);
		i_rst = 1'b0;
		n = 0;
		while (o_pc !== stop && n < 200) begin
			@(negedge i_clk);
			n++;
		end
		check(o_pc, stop);
		repeat (4) @(negedge i_clk);
	endtask
	task automatic s_call();
		mem.rom[12'h123] = 8'h71;
		mem.rom[12'h124] = 8'h45;
		run({8'h21, 8'h23}, 16'h0345);
		check(o_sp, 8'h09);
		check(mem.ram[8], 8'h25);
		check(mem.ram[9], 8'h01);
		check(o_psw, 8'h00);
	endtask
	task automatic s_add();
		run({8'h24, 8'hc3, 8'h28}, 16'h0003);
		check(o_acc, 8'h6d);
		check({o_psw[7:6], o_psw[2]}, 3'b101);
	endtask
	task automatic s_add_with_carry_op();
		run({8'h24, 8'hc3, 8'h28, 8'h38}, 16'h0004);
		check(o_acc, 8'h18);
		check({o_psw[7:6], o_psw[2]}, 3'b110);
	endtask
	task automatic s_and();
		run({8'h24, 8'hc3, 8'h28, 8'h82, 8'h01, 8'h54, 8'h5f, 8'h53, 8'h90, 8'h73, 8'h52,
			8'h21, 8'h56, 8'hb0, 8'h00}, 16'h000f);
		check(o_acc, 8'h0d);
		check(mem.special_function_register[8'h90], 8'h73);
		check(mem.ram[8'h21], 8'h40);
		check({o_psw[7:6], o_psw[2]}, 3'b001);
		check(ill_cnt, 16'h0000);
	endtask
	// illegal byte skipped, then immediate, direct, indirect via R1, sfr, immediate, direct and register forms
	task automatic s_forms();
		mem.ram[8'h01] = 8'haa;
		mem.ram[8'h02] = 8'h3c;
		run({8'h22, 8'h24, 8'h11, 8'h25, 8'h21, 8'h37, 8'h35, 8'h90, 8'h34, 8'h7f, 8'h55,
			8'h21, 8'h5a}, 16'h000d);
		check(ill_cnt, 16'h0001);
		check(o_acc, 8'h10);
		check({o_psw[7:6], o_psw[2]}, 3'b011);
	endtask
	task automatic s_bit();
		run({8'h24, 8'hc3, 8'h28, 8'hb0, 8'h01, 8'h82, 8'h00}, 16'h0007);
		check(o_psw[7], 1'b1);
		check(mem.ram[8'h20], 8'h01);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		i_rst = 1'b1;
		error_cnt = 0;
		cmp_count = 0;
		cyc = 0;
		s_call();
		s_add();
		s_add_with_carry_op();
		s_and();
		s_bit();
		s_forms();
		finish_test();
	end
endmodule
`default_nettype wire
